// >>> core/half_bridge_deadband.sv
// Added by the designer: the plain strobed port and the register addresses.
`default_nettype none
//Contract
// - delay only the inactive-to-active output edge
// - delay turn-on of both complementary outputs
// - dead band count is low seven bits
// - hold inactive exactly programmed instruction cycles
// - auto restart clears status when event ends
// - without auto restart, software clears status
// - shutdown sets status, drives selected pin states
// - count above duty keeps output inactive
// - resume at start of next period
// - status writes ignored while condition persists
module half_bridge_deadband
  import deadband_pkg::*;
#(
  parameter int CW = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic shutdown_in,
  output logic pwm_out_a,
  output logic pwm_out_a_oe,
  output logic pwm_out_b,
  output logic pwm_out_b_oe,
  output logic irq
);
  import deadband_pkg::*;

  initial begin
    if (CW != 8) $error("half_bridge_deadband: CW must be 8");
  end

  // software registers
  logic [7:0] dbctrl_q;   // restart enable and dead band count
  logic [6:0] sdctrl_q;   // source enable and shutdown states
  logic sd_status_q;      // shutdown event status
  logic [7:0] period_q;
  logic [7:0] duty_q;
  logic [2:0] mode_q;     // enable, polarity a, polarity b
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic [7:0] timer_q;    // period timer
  logic [7:0] rdata_q;

  // derived terms
  logic tick;             // one per instruction cycle
  logic period_end;       // timer reaches period on a tick
  logic sd_cond;          // level shutdown condition
  logic running_q;        // pwm allowed this period
  logic raw_pwm;          // undelayed duty signal
  logic act_a;
  logic act_b;
  logic [DB_WIDTH-1:0] db_count;
  logic wr_db;
  logic wr_sd;
  logic wr_stat;
  logic sd_status_set;

  function automatic logic decode(input logic [3:0] a, input logic [3:0] b);
    decode = (a == b);
  endfunction

  // polarity: an active output shows as the inverse when set low-active
  function automatic logic out_level(input logic act, input logic pol_low);
    out_level = act ^ pol_low;
  endfunction

  assign wr_db = reg_write & decode(reg_addr, ADDR_DBCTRL);
  assign wr_sd = reg_write & decode(reg_addr, ADDR_SDCTRL);
  assign wr_stat = reg_write & decode(reg_addr, ADDR_IRQ_STAT);
  assign db_count = dbctrl_q[DB_WIDTH-1:0];

  // instruction cycle strobe: every count is in four-clock units
  tcy_divider #(
    .DIV(TOSC_PER_TCY)
  ) u_tcy (
    .clock(clock),
    .rst_n(rst_n),
    .tick(tick)
  );

  // configuration registers written over the plain port
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dbctrl_q <= DBCTRL_RST;
      sdctrl_q <= SDCTRL_RST[6:0];
      period_q <= PERIOD_RST;
      duty_q <= DUTY_RST;
      mode_q <= MODE_RST[2:0];
      irq_mask_q <= IRQ_RST;
    end else if (reg_write) begin
      if (decode(reg_addr, ADDR_DBCTRL)) begin
        dbctrl_q <= reg_wdata;
      end else if (decode(reg_addr, ADDR_SDCTRL)) begin
        sdctrl_q <= reg_wdata[6:0];
      end else if (decode(reg_addr, ADDR_PERIOD)) begin
        period_q <= reg_wdata;
      end else if (decode(reg_addr, ADDR_DUTY)) begin
        duty_q <= reg_wdata;
      end else if (decode(reg_addr, ADDR_MODE)) begin
        mode_q <= reg_wdata[2:0];
      end else if (decode(reg_addr, ADDR_IRQ_MASK)) begin
        irq_mask_q <= reg_wdata[1:0];
      end
    end
  end

  // shutdown is level based: only the enabled external source counts
  assign sd_cond = sdctrl_q[SD_SRC_EXT_BIT] & shutdown_in;

  // status: set by the level or by software, cleared by software or by
  // auto restart; a pending condition always wins over any clear
  assign sd_status_set = sd_cond | (wr_sd & reg_wdata[SD_STATUS_BIT]);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sd_status_q <= 1'b0;
    end else if (sd_status_set) begin
      sd_status_q <= 1'b1;
    end else if (dbctrl_q[RESTART_BIT]) begin
      sd_status_q <= 1'b0;
    end else if (wr_sd) begin
      sd_status_q <= 1'b0;
    end
  end

  // period timer counted in instruction cycles
  assign period_end = tick & (timer_q >= period_q);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      timer_q <= ZERO8;
    end else if (!mode_q[MODE_EN_BIT]) begin
      timer_q <= ZERO8;
    end else if (period_end) begin
      timer_q <= ZERO8;
    end else if (tick) begin
      timer_q <= timer_q + 8'h01;
    end
  end

  // after shutdown the outputs stay idle until a fresh period starts
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      running_q <= 1'b0;
    end else if (sd_status_q || !mode_q[MODE_EN_BIT]) begin
      running_q <= 1'b0;
    end else if (period_end) begin
      running_q <= 1'b1;
    end
  end

  assign raw_pwm = running_q & (timer_q < duty_q);

  // each side waits the dead band before it turns on
  deadband_delay #(
    .W(DB_WIDTH)
  ) u_dly_a (
    .clock(clock),
    .rst_n(rst_n),
    .tick(tick),
    .request(raw_pwm & ~sd_status_q),
    .delay(db_count),
    .active(act_a)
  );

  deadband_delay #(
    .W(DB_WIDTH)
  ) u_dly_b (
    .clock(clock),
    .rst_n(rst_n),
    .tick(tick),
    .request(running_q & ~raw_pwm & ~sd_status_q),
    .delay(db_count),
    .active(act_b)
  );

  // pin drive: shutdown state codes override the pwm; 1x releases the pin
  always_comb begin
    pwm_out_a = out_level(act_a, mode_q[MODE_POL_A_BIT]);
    pwm_out_b = out_level(act_b, mode_q[MODE_POL_B_BIT]);
    pwm_out_a_oe = mode_q[MODE_EN_BIT];
    pwm_out_b_oe = mode_q[MODE_EN_BIT];
    if (sd_status_q) begin
      pwm_out_a = sdctrl_q[SD_STATE_A_LO];
      pwm_out_b = sdctrl_q[SD_STATE_B_LO];
      pwm_out_a_oe = mode_q[MODE_EN_BIT] & ~sdctrl_q[SD_STATE_A_HI];
      pwm_out_b_oe = mode_q[MODE_EN_BIT] & ~sdctrl_q[SD_STATE_B_HI];
    end
  end

  // interrupt status: set beats write-one-to-clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= IRQ_RST;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == IRQ_SHUTDOWN_BIT && sd_status_set && !sd_status_q) ||
            (i == IRQ_PERIOD_BIT && period_end)) begin
          irq_stat_q[i] <= 1'b1;
        end else if (wr_stat && reg_wdata[i]) begin
          irq_stat_q[i] <= 1'b0;
        end
      end
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // read data valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= ZERO8;
    end else if (reg_read) begin
      if (decode(reg_addr, ADDR_DBCTRL)) begin
        rdata_q <= dbctrl_q;
      end else if (decode(reg_addr, ADDR_SDCTRL)) begin
        rdata_q <= {sd_status_q, sdctrl_q};
      end else if (decode(reg_addr, ADDR_PERIOD)) begin
        rdata_q <= period_q;
      end else if (decode(reg_addr, ADDR_DUTY)) begin
        rdata_q <= duty_q;
      end else if (decode(reg_addr, ADDR_MODE)) begin
        rdata_q <= {5'h00, mode_q};
      end else if (decode(reg_addr, ADDR_IRQ_STAT)) begin
        rdata_q <= {6'h00, irq_stat_q};
      end else if (decode(reg_addr, ADDR_IRQ_MASK)) begin
        rdata_q <= {6'h00, irq_mask_q};
      end else if (decode(reg_addr, ADDR_TIMER)) begin
        rdata_q <= timer_q;
      end else begin
        rdata_q <= ZERO8;
      end
    end else begin
      rdata_q <= ZERO8;
    end
  end

  assign reg_rdata = rdata_q;
endmodule
`default_nettype wire

// >>> core/deadband_pkg.sv
`default_nettype none
package deadband_pkg;
  // register offsets (byte addresses on the plain register port)
  localparam logic [3:0] ADDR_DBCTRL = 4'h0;  // dead band / restart
  localparam logic [3:0] ADDR_SDCTRL = 4'h1;  // shutdown control
  localparam logic [3:0] ADDR_PERIOD = 4'h2;  // period limit
  localparam logic [3:0] ADDR_DUTY = 4'h3;    // duty count
  localparam logic [3:0] ADDR_MODE = 4'h4;    // enable and polarity
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h5;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
  localparam logic [3:0] ADDR_TIMER = 4'h7;   // period timer count, read only
  // field positions
  localparam int RESTART_BIT = 7;
  localparam int SD_STATUS_BIT = 7;
  localparam int SD_SRC_EXT_BIT = 6;
  localparam int SD_STATE_A_HI = 3;
  localparam int SD_STATE_A_LO = 2;
  localparam int SD_STATE_B_HI = 1;
  localparam int SD_STATE_B_LO = 0;
  localparam int MODE_EN_BIT = 0;
  localparam int MODE_POL_A_BIT = 1;
  localparam int MODE_POL_B_BIT = 2;
  localparam int IRQ_SHUTDOWN_BIT = 0;
  localparam int IRQ_PERIOD_BIT = 1;
  // reset values
  localparam logic [7:0] DBCTRL_RST = 8'h00;
  localparam logic [7:0] SDCTRL_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hff;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [1:0] IRQ_RST = 2'h0;
  // shutdown pin state codes
  localparam logic [1:0] SD_DRIVE_LOW = 2'h0;
  localparam logic [1:0] SD_DRIVE_HIGH = 2'h1;
  // clock and instruction cycle
  localparam int CLOCK_HZ = 50_000_000;
  localparam int TOSC_PER_TCY = 4;
  localparam int DB_WIDTH = 7;
  localparam logic [7:0] ZERO8 = 8'h00;
endpackage
`default_nettype wire

// >>> core/tcy_divider.sv
`default_nettype none
// makes a one-cycle pulse every instruction cycle (four clocks)
module tcy_divider #(
  parameter int DIV = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  output logic tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] count_q; // free running phase
  initial begin
    if (DIV < 1) $error("tcy_divider: DIV must be at least 1");
  end
  // free-running phase counter
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
    end else if (count_q == LAST) begin
      count_q <= '0;
    end else begin
      count_q <= count_q + CW'(1);
    end
  end
  assign tick = (count_q == LAST);
endmodule
`default_nettype wire

// >>> core/deadband_delay.sv
`default_nettype none
// delays the rising edge of one active-high request by a count of ticks;
// the falling edge passes at once
module deadband_delay #(
  parameter int W = 7
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic request,
  input wire logic [W-1:0] delay,
  output logic active
);
  logic [W-1:0] remain_q; // ticks still to wait
  logic req_q;            // request seen last cycle
  logic active_q;
  initial begin
    if (W < 1) $error("deadband_delay: W must be at least 1");
  end
  // request history for edge detection
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      req_q <= 1'b0;
    end else begin
      req_q <= request;
    end
  end
  // the count is latched only at the scheduled edge, so a new value
  // never stretches or shortens a wait already running
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      remain_q <= '0;
      active_q <= 1'b0;
    end else if (!request) begin
      active_q <= 1'b0;
      remain_q <= '0;
    end else if (!req_q) begin
      remain_q <= delay;
      active_q <= (delay == '0);
    end else if (!active_q && tick) begin
      if (remain_q <= W'(1)) begin
        active_q <= 1'b1;
        remain_q <= '0;
      end else begin
        remain_q <= remain_q - W'(1);
      end
    end
  end
  // a request shorter than the delay never reaches the output; a zero
  // count passes the rising edge in the same cycle so no clock is lost
  assign active = request & (active_q | (!req_q && delay == '0));
endmodule
`default_nettype wire

// >>> testbench/half_bridge_sva.sv
`default_nettype none
// register port and shutdown pin checks, seen from the top ports only
module half_bridge_sva
  import deadband_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic shutdown_in,
  input wire logic pwm_out_a,
  input wire logic pwm_out_a_oe,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh_q [4]; // mirror of the plain read-write registers
  logic [7:0] sd_q; // last value written to shutdown control
  logic [1:0] mask_q; // mirror of the interrupt mask
  logic [7:0] exp_q; // mirror value caught at a read
  // mirrors follow bus writes; status bits are not mirrored (hardware owned)
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sh_q <= '{DBCTRL_RST, SDCTRL_RST, PERIOD_RST, DUTY_RST};
      sd_q <= SDCTRL_RST;
      mask_q <= IRQ_RST;
      exp_q <= ZERO8;
    end else begin
      exp_q <= sh_q[reg_addr[1:0]];
      if (reg_write && reg_addr < ADDR_MODE) sh_q[reg_addr[1:0]] <= reg_wdata;
      if (reg_write && reg_addr == ADDR_SDCTRL) sd_q <= reg_wdata;
      if (reg_write && reg_addr == ADDR_IRQ_MASK) mask_q <= reg_wdata[1:0];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // external event present and enabled for three cycles in a row
  sequence held_event;
    (shutdown_in && sd_q[SD_SRC_EXT_BIT]) [*3];
  endsequence
  // software forces shutdown with pin a in the given state
  sequence force_a(logic [1:0] st);
    reg_write && reg_addr == ADDR_SDCTRL && reg_wdata[7]
      && reg_wdata[3:2] == st;
  endsequence
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == ZERO8)
    else $error("read data not zero outside read slot");
  a_rd_plain: assert property (reg_read && reg_addr != ADDR_SDCTRL
    && reg_addr < ADDR_MODE |=> reg_rdata == exp_q)
    else $error("register read back differs from last write");
  a_rd_unmapped: assert property (reg_read && reg_addr > ADDR_TIMER
    |=> reg_rdata == ZERO8) else $error("unmapped read not zero");
  a_irq_masked: assert property (mask_q == 2'h0 && $past(mask_q) == 2'h0
    |-> !irq) else $error("interrupt raised while masked");
  a_status_held: assert property (held_event ##0 (reg_read
    && reg_addr == ADDR_SDCTRL) |=> reg_rdata[SD_STATUS_BIT])
    else $error("status lost while event persists");
  a_force_tri: assert property (force_a(2'h2) |-> ##[1:3] !pwm_out_a_oe)
    else $error("pin a not released on tri-state shutdown");
  a_force_low: assert property (force_a(2'h0) |-> ##[1:3] !pwm_out_a)
    else $error("pin a not low on forced shutdown");
  a_held_low: assert property (held_event ##0 sd_q[3:2] == 2'h0
    |-> !pwm_out_a) else $error("pin a not low during shutdown");
endmodule
bind half_bridge_deadband half_bridge_sva chk (.clock(clock), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .shutdown_in(shutdown_in),
  .pwm_out_a(pwm_out_a), .pwm_out_a_oe(pwm_out_a_oe), .irq(irq));
`default_nettype wire

// >>> testbench/gate_drive_model.sv
`default_nettype none
// half-bridge gate drive: high switch follows pin a, low switch pin b
module gate_drive_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic pwm_out_a,
  input wire logic pwm_out_a_oe,
  input wire logic pwm_out_b,
  input wire logic pwm_out_b_oe,
  output logic [7:0] overlaps
);
  timeunit 1ns;
  timeprecision 1ns;
  // gates have pull-downs, so a released pin leaves its switch off
  wire logic hi_on = pwm_out_a_oe & pwm_out_a;
  wire logic lo_on = pwm_out_b_oe & pwm_out_b;
  // count shoot-through clocks, saturating so a storm cannot wrap to zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) overlaps <= 8'h00;
    else if (hi_on && lo_on && overlaps != 8'hff) overlaps <= overlaps + 8'h01;
  end
endmodule
`default_nettype wire

// >>> testbench/tb_half_bridge_deadband.sv
`default_nettype none
module tb_half_bridge_deadband;
  timeunit 1ns;
  timeprecision 1ns;
  import deadband_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0, reg_read = 1'b0, shutdown_in = 1'b0, rd_seen = 1'b0;
  logic [7:0] reg_rdata, overlaps;
  logic pwm_out_a, pwm_out_a_oe, pwm_out_b, pwm_out_b_oe, irq;
  logic [7:0] exp_q [$]; // read results still owed by the design
  logic [7:0] dbs [3] = '{8'h00, 8'h02, 8'h03};
  int num_errors = 0, compares = 0, seed = 32'ha5a45e93, w;
  always #10 clock = ~clock;
  half_bridge_deadband uut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .shutdown_in(shutdown_in), .pwm_out_a(pwm_out_a),
    .pwm_out_a_oe(pwm_out_a_oe), .pwm_out_b(pwm_out_b),
    .pwm_out_b_oe(pwm_out_b_oe), .irq(irq));
  gate_drive_model drv (.clock(clock), .rst_n(rst_n), .pwm_out_a(pwm_out_a),
    .pwm_out_a_oe(pwm_out_a_oe), .pwm_out_b(pwm_out_b),
    .pwm_out_b_oe(pwm_out_b_oe), .overlaps(overlaps));
  task automatic chk(input logic [7:0] got, input logic [7:0] e);
    compares++;
    if (got !== e) begin
      num_errors++;
      $display("Error %0t: got %h want %h", $time, got, e);
    end
  endtask
  // one-cycle strobes; a gap cycle keeps each strobe assigned once per step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
  endtask
  // read data stand only in the cycle after the strobe: check mid-cycle
  always @(posedge clock) rd_seen <= reg_read;
  always @(negedge clock) if (rd_seen) chk(reg_rdata, exp_q.pop_front());
  task automatic pins(input logic [7:0] e);
    @(negedge clock);
    chk({3'h0, pwm_out_a_oe, pwm_out_b_oe, pwm_out_a, pwm_out_b, irq}, e);
    @(posedge clock);
  endtask
  // width in clocks of the next high pulse on a pin, zero if none comes
  task automatic pulse(input bit s, output int n);
    n = 0;
    for (int i = 0; i < 400 && (s ? pwm_out_b : pwm_out_a); i++) @(negedge clock);
    for (int i = 0; i < 400 && !(s ? pwm_out_b : pwm_out_a); i++) @(negedge clock);
    while (n < 400 && (s ? pwm_out_b : pwm_out_a)) begin
      @(negedge clock);
      n++;
    end
    @(posedge clock);
  endtask
  task automatic give_verdict;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 8; i++) rd(4'(i), i == 2 ? PERIOD_RST : ZERO8);
    rd(4'h9, ZERO8);
    $display("reset values done");
    repeat (4) begin
      w = $random(seed);
      wr(ADDR_DUTY, w[7:0]);
      rd(ADDR_DUTY, w[7:0]);
      wr(ADDR_DBCTRL, w[15:8]);
      rd(ADDR_DBCTRL, w[15:8]);
    end
    $display("random round trip done");
    // ten ticks a period, a requested for four of them, b for six
    wr(ADDR_PERIOD, 8'h09);
    wr(ADDR_DUTY, 8'h04);
    wr(ADDR_MODE, 8'h01);
    foreach (dbs[k]) begin
      wr(ADDR_DBCTRL, dbs[k]);
      repeat (80) @(posedge clock);
      pulse(1'b0, w);
      chk(8'(w), 8'(16 - 4 * dbs[k]));
      pulse(1'b1, w);
      chk(8'(w), 8'(24 - 4 * dbs[k]));
    end
    wr(ADDR_DBCTRL, 8'h05);
    repeat (80) @(posedge clock);
    pulse(1'b0, w);
    chk(8'(w), 8'h00);
    chk(overlaps, ZERO8);
    $display("dead band done");
    wr(ADDR_DBCTRL, 8'h02);
    wr(ADDR_IRQ_MASK, 8'h01);
    wr(ADDR_SDCTRL, 8'h41); // external source, a drives low, b drives high
    shutdown_in <= 1'b1;
    repeat (4) @(posedge clock);
    pins(8'h1b);
    wr(ADDR_SDCTRL, 8'h41); // clear attempt while the event persists
    rd(ADDR_SDCTRL, 8'hc1);
    shutdown_in <= 1'b0;
    repeat (8) @(posedge clock);
    rd(ADDR_SDCTRL, 8'hc1);
    wr(ADDR_IRQ_MASK, 8'h00);
    pins(8'h1a);
    wr(ADDR_IRQ_STAT, 8'h01);
    wr(ADDR_IRQ_MASK, 8'h01);
    pins(8'h1a);
    wr(ADDR_SDCTRL, 8'h41); // software restart
    rd(ADDR_SDCTRL, 8'h41);
    pulse(1'b0, w);
    chk(8'(w), 8'h08);
    $display("software restart done");
    wr(ADDR_DBCTRL, 8'h82);
    shutdown_in <= 1'b1;
    repeat (4) @(posedge clock);
    rd(ADDR_SDCTRL, 8'hc1);
    shutdown_in <= 1'b0;
    repeat (3) @(posedge clock);
    rd(ADDR_SDCTRL, 8'h41);
    pulse(1'b0, w);
    chk(8'(w), 8'h08);
    wr(ADDR_SDCTRL, 8'hc8); // forced, a released, b low
    wr(ADDR_SDCTRL, 8'h80); // forced, both low
    repeat (60) @(posedge clock);
    chk(overlaps, ZERO8);
    $display("auto restart done");
    give_verdict();
  end
  initial begin
    #400_000;
    num_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
